// ===== rtl/cswk_pkg.sv
/*
 Constants, register map and carrier types for the CAN selective wake configuration block.
 Assumes a 40 MHz core clock and an SPI host whose pins are already synchronous to it.
*/
// Operation
// - Control bit 7 switches oscillator trim mode on when 1, off when 0.
// - Unlock field bits 6:5 unlocks recalibration only at value 11.
// - Trim active and unlocked: transmit input pin is the trimming reference.
// - Wake option register accepts writes only while unlock field holds 11.
// - Timeout enable bit 4: 0 blocks timeout interrupt, 1 signals it.
// - Timeout flag updates, interrupt raised, only while selective wake enabled, Normal/Stop; the code sets the flag in any mode.
// - Control bits 3:1 are reserved and read as zero.
// - Host sets valid bit 0; selective wake enabled only while it is 1.
// - Valid bit self-clears on wake-up, power-on reset, or changed config data.
// - In Stop mode any config register write forces the valid bit to 0.
// - Eight-bit field sets time quanta per CAN bit.
// - Six-bit sample point is a fraction: field value divided by 64.
// - 29-bit identifier spans four registers, lowest five bits at 6:2.
// - Expected remote bit 1: 0 data frame, 1 remote request.
// - Extension bit 0: 0 standard 11-bit, 1 extended 29-bit identifier.
// - Mask bit 1 compares that identifier bit, 0 ignores it.
// - Configured data length code must equal received code bit for bit.
`default_nettype none
package cswk_pkg;
    // Register addresses on the 7-bit SPI address field
    localparam logic [6:0] ADDR_CTRL     = 7'h20;
    localparam logic [6:0] ADDR_QUANTA   = 7'h21;
    localparam logic [6:0] ADDR_SAMPLE   = 7'h22;
    localparam logic [6:0] ADDR_ID3      = 7'h23;
    localparam logic [6:0] ADDR_ID2      = 7'h24;
    localparam logic [6:0] ADDR_ID1      = 7'h25;
    localparam logic [6:0] ADDR_ID0      = 7'h26;
    localparam logic [6:0] ADDR_MASK3    = 7'h27;
    localparam logic [6:0] ADDR_WAKE_OPT = 7'h3e;
    // Field positions
    localparam int CTRL_TRIM_MODE_BIT = 7;
    localparam int CTRL_UNLOCK_HI     = 6;
    localparam int CTRL_UNLOCK_LO     = 5;
    localparam int CTRL_TO_IRQ_BIT    = 4;
    localparam int CTRL_VALID_BIT     = 0;
    localparam int ID0_LOW_HI         = 6;
    localparam int ID0_LOW_LO         = 2;
    localparam int ID0_RTR_BIT        = 1;
    localparam int ID0_IDE_BIT        = 0;
    localparam int STD_ID_LSB         = 18;
    localparam logic [1:0] UNLOCK_KEY = 2'h3;
    // Reset values
    localparam logic [7:0] RST_CTRL    = 8'h00;
    localparam logic [7:0] RST_QUANTA  = 8'ha0;
    localparam logic [7:0] RST_SAMPLE  = 8'h33;
    localparam logic [7:0] RST_ID      = 8'h00;
    localparam logic [7:0] RST_MASK    = 8'h00;
    localparam logic [7:0] RST_OPT     = 8'h00;
    // SPI frame: write flag, 7-bit address, 8-bit data
    localparam logic [4:0] SPI_FRAME_BITS = 5'h10;
    localparam logic [4:0] SPI_ADDR_BITS  = 5'h08;

    // Received frame summary from the protocol decoder
    typedef struct packed {
        logic [28:0] id;
        logic        ide;
        logic        rtr;
        logic [3:0]  dlc;
    } cswk_frame_t;

    // Whole state of the configuration block
    typedef struct packed {
        logic        sclk_q;
        logic        csn_q;
        logic [4:0]  cnt;
        logic [15:0] shift;
        logic [7:0]  out;
        logic        miso;
        logic        trim_mode;
        logic [1:0]  unlock;
        logic        to_irq_en;
        logic        valid;
        logic [7:0]  quanta;
        logic [5:0]  sample;
        logic [28:0] id;
        logic        rtr;
        logic        ide;
        logic [7:0]  mask_upper;
        logic [7:0]  wake_opt;
        logic        to_flag;
        logic        irq;
        logic        match;
        logic        trim_ref;
    } cswk_state_t;
endpackage : cswk_pkg
`default_nettype wire

// ===== rtl/cswk_config.sv
/*
 Selective wake configuration registers with a 16-bit SPI slave, timeout interrupt and
 wake frame comparison. Assumes SPI pins synchronous to clk, SPI mode 0, MSB first.
*/
`default_nettype none
module cswk_config (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  soft_reset,
    input  wire logic                  spi_csn_n,
    input  wire logic                  spi_sclk,
    input  wire logic                  spi_mosi,
    output logic                       spi_miso,
    input  wire logic                  normal_mode,
    input  wire logic                  stop_mode,
    input  wire logic                  wake_event,
    input  wire logic                  bus_timeout_event,
    input  wire logic                  bus_timeout_clear,
    input  wire logic                  transmit_input_pin,
    input  wire logic [20:0]           mask_lower,
    input  wire logic [3:0]            cfg_dlc,
    input  wire logic                  rx_frame_valid,
    input  wire cswk_pkg::cswk_frame_t rx_frame,
    output logic                       osc_trim_mode_enable,
    output logic                       trim_unlocked,
    output logic                       trim_sync_ref,
    output logic                       wake_config_valid,
    output logic [7:0]                 quanta_per_bit,
    output logic [5:0]                 sample_point_fraction,
    output logic                       low_power_rx_enable,
    output logic                       bus_timeout_flag,
    output logic                       bus_timeout_irq,
    output logic                       wake_up_frame
);
    cswk_pkg::cswk_state_t s;
    cswk_pkg::cswk_state_t next_s;

    // Power-on and soft reset image; SPI shifter included so a soft reset aborts a frame
    function automatic cswk_pkg::cswk_state_t cswk_reset_state();
        cswk_pkg::cswk_state_t r;
        r            = '0;
        r.sclk_q     = 1'b0;
        r.csn_q      = 1'b1;
        r.trim_mode  = cswk_pkg::RST_CTRL[cswk_pkg::CTRL_TRIM_MODE_BIT];
        r.unlock     = cswk_pkg::RST_CTRL[cswk_pkg::CTRL_UNLOCK_HI:cswk_pkg::CTRL_UNLOCK_LO];
        r.to_irq_en  = cswk_pkg::RST_CTRL[cswk_pkg::CTRL_TO_IRQ_BIT];
        r.valid      = cswk_pkg::RST_CTRL[cswk_pkg::CTRL_VALID_BIT];
        r.quanta     = cswk_pkg::RST_QUANTA;
        r.sample     = cswk_pkg::RST_SAMPLE[5:0];
        r.id         = {cswk_pkg::RST_ID, cswk_pkg::RST_ID, cswk_pkg::RST_ID,
                        cswk_pkg::RST_ID[6:2]};
        r.rtr        = cswk_pkg::RST_ID[cswk_pkg::ID0_RTR_BIT];
        r.ide        = cswk_pkg::RST_ID[cswk_pkg::ID0_IDE_BIT];
        r.mask_upper = cswk_pkg::RST_MASK;
        r.wake_opt   = cswk_pkg::RST_OPT;
        return r;
    endfunction : cswk_reset_state

    // Read view of one register; reserved bits and unmapped addresses give zero
    function automatic logic [7:0] cswk_read(input logic [6:0] a,
                                             input cswk_pkg::cswk_state_t r);
        logic [7:0] d;
        d = 8'h00;
        if (a == cswk_pkg::ADDR_CTRL)
        begin
            d = {r.trim_mode, r.unlock, r.to_irq_en, 3'h0, r.valid};
        end
        else if (a == cswk_pkg::ADDR_QUANTA)
        begin
            d = r.quanta;
        end
        else if (a == cswk_pkg::ADDR_SAMPLE)
        begin
            d = {2'h0, r.sample};
        end
        else if (a == cswk_pkg::ADDR_ID3)
        begin
            d = r.id[28:21];
        end
        else if (a == cswk_pkg::ADDR_ID2)
        begin
            d = r.id[20:13];
        end
        else if (a == cswk_pkg::ADDR_ID1)
        begin
            d = r.id[12:5];
        end
        else if (a == cswk_pkg::ADDR_ID0)
        begin
            d = {1'b0, r.id[4:0], r.rtr, r.ide};
        end
        else if (a == cswk_pkg::ADDR_MASK3)
        begin
            d = r.mask_upper;
        end
        else if (a == cswk_pkg::ADDR_WAKE_OPT)
        begin
            d = r.wake_opt;
        end
        return d;
    endfunction : cswk_read

    logic        sclk_rise;
    logic        sclk_fall;
    logic        commit;
    logic [6:0]  waddr;
    logic [7:0]  wdata;
    logic        cfg_write;
    logic        cfg_changed;
    logic [28:0] full_mask;
    logic [28:0] eff_mask;
    logic        frame_hit;

    // SPI edges and the write taken at chip-select release after 16 or more clocks
    assign sclk_rise = spi_sclk & ~s.sclk_q & ~spi_csn_n;
    assign sclk_fall = ~spi_sclk & s.sclk_q & ~spi_csn_n;
    assign commit    = spi_csn_n & ~s.csn_q & (s.cnt == cswk_pkg::SPI_FRAME_BITS) & s.shift[15];
    assign waddr     = s.shift[14:8];
    assign wdata     = s.shift[7:0];

    // Any write to the configuration range, and whether it alters stored data
    assign cfg_write = commit & (((waddr >= cswk_pkg::ADDR_CTRL) &
                                  (waddr <= cswk_pkg::ADDR_MASK3)) |
                                 (waddr == cswk_pkg::ADDR_WAKE_OPT));
    always_comb
    begin
        cfg_changed = 1'b0;
        if (waddr == cswk_pkg::ADDR_QUANTA)
        begin
            cfg_changed = (wdata != s.quanta);
        end
        else if (waddr == cswk_pkg::ADDR_SAMPLE)
        begin
            cfg_changed = (wdata[5:0] != s.sample);
        end
        else if (waddr == cswk_pkg::ADDR_ID0)
        begin
            // Reserved bit 7 holds no data, so writing it must not count as a change
            cfg_changed = ({1'b0, wdata[6:0]} != cswk_read(waddr, s));
        end
        else if ((waddr >= cswk_pkg::ADDR_ID3) && (waddr <= cswk_pkg::ADDR_MASK3))
        begin
            cfg_changed = (wdata != cswk_read(waddr, s));
        end
        else if (waddr == cswk_pkg::ADDR_WAKE_OPT)
        begin
            cfg_changed = (s.unlock == cswk_pkg::UNLOCK_KEY) && (wdata != s.wake_opt);
        end
    end

    // Standard frames compare only the upper eleven identifier positions
    assign full_mask = {s.mask_upper, mask_lower};
    assign eff_mask  = s.ide ? full_mask : {full_mask[28:cswk_pkg::STD_ID_LSB], 18'h0};
    assign frame_hit = rx_frame_valid & s.valid
                     & (((rx_frame.id ^ s.id) & eff_mask) == 29'h0)
                     & (rx_frame.ide == s.ide)
                     & (rx_frame.rtr == s.rtr)
                     & (rx_frame.dlc == cfg_dlc);

    // Next-state: SPI shifter, register writes, valid housekeeping, timeout, match
    always_comb
    begin
        next_s        = s;
        next_s.sclk_q = spi_sclk;
        next_s.csn_q  = spi_csn_n;
        if (spi_csn_n)
        begin
            next_s.cnt  = 5'h00;
            next_s.miso = 1'b0;
        end
        else if (sclk_rise)
        begin
            next_s.shift = {s.shift[14:0], spi_mosi};
            if (s.cnt != cswk_pkg::SPI_FRAME_BITS)
            begin
                next_s.cnt = s.cnt + 5'h01;
            end
            // Address complete: fetch the read byte for the data phase
            if (s.cnt == (cswk_pkg::SPI_ADDR_BITS - 5'h01))
            begin
                next_s.out = cswk_read({s.shift[5:0], spi_mosi}, s);
            end
        end
        else if (sclk_fall && (s.cnt >= cswk_pkg::SPI_ADDR_BITS))
        begin
            next_s.miso = s.out[7];
            next_s.out  = {s.out[6:0], 1'b0};
        end

        if (commit)
        begin
            if (waddr == cswk_pkg::ADDR_CTRL)
            begin
                next_s.trim_mode = wdata[cswk_pkg::CTRL_TRIM_MODE_BIT];
                next_s.unlock    = wdata[cswk_pkg::CTRL_UNLOCK_HI:cswk_pkg::CTRL_UNLOCK_LO];
                next_s.to_irq_en = wdata[cswk_pkg::CTRL_TO_IRQ_BIT];
                next_s.valid     = wdata[cswk_pkg::CTRL_VALID_BIT];
            end
            else if (waddr == cswk_pkg::ADDR_QUANTA)
            begin
                next_s.quanta = wdata;
            end
            else if (waddr == cswk_pkg::ADDR_SAMPLE)
            begin
                next_s.sample = wdata[5:0];
            end
            else if (waddr == cswk_pkg::ADDR_ID3)
            begin
                next_s.id[28:21] = wdata;
            end
            else if (waddr == cswk_pkg::ADDR_ID2)
            begin
                next_s.id[20:13] = wdata;
            end
            else if (waddr == cswk_pkg::ADDR_ID1)
            begin
                next_s.id[12:5] = wdata;
            end
            else if (waddr == cswk_pkg::ADDR_ID0)
            begin
                next_s.id[4:0] = wdata[cswk_pkg::ID0_LOW_HI:cswk_pkg::ID0_LOW_LO];
                next_s.rtr     = wdata[cswk_pkg::ID0_RTR_BIT];
                next_s.ide     = wdata[cswk_pkg::ID0_IDE_BIT];
            end
            else if (waddr == cswk_pkg::ADDR_MASK3)
            begin
                next_s.mask_upper = wdata;
            end
            else if ((waddr == cswk_pkg::ADDR_WAKE_OPT) && (s.unlock == cswk_pkg::UNLOCK_KEY))
            begin
                next_s.wake_opt = wdata;
            end
        end

        // Invalidation wins over a host set in the same cycle: a stale config must not wake
        if (wake_event || frame_hit || (cfg_write && cfg_changed))
        begin
            next_s.valid = 1'b0;
        end
        if (cfg_write && stop_mode)
        begin
            next_s.valid = 1'b0;
        end

        // Timeout flag only tracks the bus while selective wake is enabled; set beats clear
        if (bus_timeout_event && s.valid)
        begin
            next_s.to_flag = 1'b1;
        end
        else if (bus_timeout_clear)
        begin
            next_s.to_flag = 1'b0;
        end
        next_s.irq = s.to_flag & s.to_irq_en & s.valid & (normal_mode | stop_mode);

        next_s.match    = frame_hit;
        // Reference passes only while mode is on and unlock key present
        next_s.trim_ref = s.trim_mode & (s.unlock == cswk_pkg::UNLOCK_KEY)
                        & transmit_input_pin;

        if (soft_reset)
        begin
            next_s = cswk_reset_state();
        end
    end

    // State register; power-on reset loads the reset image, which clears the valid bit
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= cswk_reset_state();
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register
    assign spi_miso              = s.miso;
    assign osc_trim_mode_enable  = s.trim_mode;
    assign trim_unlocked         = (s.unlock == cswk_pkg::UNLOCK_KEY);
    assign trim_sync_ref         = s.trim_ref;
    assign wake_config_valid     = s.valid;
    assign quanta_per_bit        = s.quanta;
    assign sample_point_fraction = s.sample;
    assign low_power_rx_enable   = s.wake_opt[0];
    assign bus_timeout_flag      = s.to_flag;
    assign bus_timeout_irq       = s.irq;
    assign wake_up_frame         = s.match;
endmodule : cswk_config
`default_nettype wire

// ===== tb/cswk_props.sv
/*
 Port-level checker for the selective wake configuration block.
 Assumes it is bound to cswk_config and that the block has one clock domain.
*/
`default_nettype none
module cswk_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_reset,
    input wire logic normal_mode,
    input wire logic stop_mode,
    input wire logic wake_event,
    input wire logic bus_timeout_event,
    input wire logic transmit_input_pin,
    input wire logic rx_frame_valid,
    input wire logic spi_csn_n,
    input wire logic osc_trim_mode_enable,
    input wire logic trim_unlocked,
    input wire logic trim_sync_ref,
    input wire logic wake_config_valid,
    input wire logic bus_timeout_flag,
    input wire logic bus_timeout_irq,
    input wire logic wake_up_frame
);
    timeunit 1ns;
    timeprecision 1ps;

    // Single domain, so clock and reset are stated once
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Trim, timeout, validity and match timing against their causes
    // A soft reset clears the reference regardless of the previous trim state
    a_trim_ref_path: assert property (
        !$past(soft_reset) |->
        trim_sync_ref == $past(osc_trim_mode_enable && trim_unlocked && transmit_input_pin))
        else $error("trim reference mismatch");
    a_irq_cause: assert property (
        bus_timeout_irq |-> $past(bus_timeout_flag && wake_config_valid
                                  && (normal_mode || stop_mode)))
        else $error("timeout interrupt without cause");
    a_flag_cause: assert property (
        $rose(bus_timeout_flag) |-> $past(bus_timeout_event && wake_config_valid))
        else $error("timeout flag set while invalid");
    a_wake_clears: assert property (
        wake_event |=> !wake_config_valid)
        else $error("valid kept after wake event");
    a_match_pulse: assert property (
        wake_up_frame |=> !wake_up_frame)
        else $error("wake frame pulse too long");
    a_match_cause: assert property (
        wake_up_frame |-> $past(rx_frame_valid && wake_config_valid))
        else $error("wake frame without valid frame");
    a_match_clears: assert property (
        wake_up_frame |-> !wake_config_valid)
        else $error("valid kept after wake frame");
    a_valid_rise: assert property (
        $rose(wake_config_valid) |-> spi_csn_n && !$past(stop_mode) && !$past(wake_event))
        else $error("valid set without host write");
endmodule : cswk_props
`default_nettype wire

// ===== tb/cswk_host.sv
/*
 Host microcontroller model: SPI master of 16-bit frames.
 Assumes SPI mode 0, MSB first, pins sampled by the block on clk.
*/
`default_nettype none
module cswk_host (
    input  wire logic clk,
    output logic      spi_csn_n,
    output logic      spi_sclk,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle bus: deselected, clock low
    initial
    begin
        spi_csn_n = 1'b1;
        spi_sclk  = 1'b0;
        spi_mosi  = 1'b0;
    end

    // Low phase of three cycles so the read bit has settled before the rise
    task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
        rd = 8'h00;
        for (int i = 15; i >= 0; i--)
        begin
            @(posedge clk);
            spi_csn_n <= 1'b0;
            spi_sclk  <= 1'b0;
            spi_mosi  <= f[i];
            repeat (3) @(posedge clk);
            spi_sclk <= 1'b1;
            if (i < 8)
                rd[i] = spi_miso;
            @(posedge clk);
        end
        @(posedge clk);
        spi_sclk <= 1'b0;
        repeat (2) @(posedge clk);
        spi_csn_n <= 1'b1;
        spi_mosi  <= ~spi_mosi; // Released line does not keep the last bit
        repeat (4) @(posedge clk);
    endtask : xfer
endmodule : cswk_host
`default_nettype wire

// ===== tb/tb.sv
/*
 Self-checking bench for the selective wake configuration block.
 Assumes cswk_pkg, cswk_config, cswk_host and cswk_props are compiled first.
*/
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [28:0] WID = 29'h0acf1357;
    logic                  clk = 1'b0, rst_n = 1'b0, soft_reset = 1'b0, wake_event = 1'b0;
    logic                  stop_mode = 1'b0, normal_mode = 1'b1, bus_timeout_event = 1'b0;
    logic                  bus_timeout_clear = 1'b0, transmit_input_pin = 1'b0;
    logic                  rx_frame_valid = 1'b0;
    logic [20:0]           mask_lower = 21'h1ffffe;
    logic [3:0]            cfg_dlc = 4'h3;
    cswk_pkg::cswk_frame_t rx_frame = '0;
    logic                  spi_csn_n, spi_sclk, spi_mosi, spi_miso, osc_trim_mode_enable;
    logic                  trim_unlocked, trim_sync_ref, wake_config_valid, low_power_rx_enable;
    logic                  bus_timeout_flag, bus_timeout_irq, wake_up_frame;
    logic [7:0]            quanta_per_bit, rb;
    logic [5:0]            sample_point_fraction;
    int                    miscompares = 0, comparisons = 0;

    cswk_config DUT (
        .clk(clk),
        .rst_n(rst_n),
        .soft_reset(soft_reset),
        .spi_csn_n(spi_csn_n),
        .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .normal_mode(normal_mode),
        .stop_mode(stop_mode),
        .wake_event(wake_event),
        .bus_timeout_event(bus_timeout_event),
        .bus_timeout_clear(bus_timeout_clear),
        .transmit_input_pin(transmit_input_pin),
        .mask_lower(mask_lower),
        .cfg_dlc(cfg_dlc),
        .rx_frame_valid(rx_frame_valid),
        .rx_frame(rx_frame),
        .osc_trim_mode_enable(osc_trim_mode_enable),
        .trim_unlocked(trim_unlocked),
        .trim_sync_ref(trim_sync_ref),
        .wake_config_valid(wake_config_valid),
        .quanta_per_bit(quanta_per_bit),
        .sample_point_fraction(sample_point_fraction),
        .low_power_rx_enable(low_power_rx_enable),
        .bus_timeout_flag(bus_timeout_flag),
        .bus_timeout_irq(bus_timeout_irq),
        .wake_up_frame(wake_up_frame)
    );
    cswk_host u_host (
        .clk(clk),
        .spi_csn_n(spi_csn_n),
        .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso)
    );

    initial forever #12.5 clk = ~clk;

    // Comparison and register access helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic chk1(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask : chk1
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_host.xfer({1'b1, a, d}, rb);
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        u_host.xfer({1'b0, a, 8'h00}, rb);
        chk(rb, exp);
    endtask : rd

    // Reset image, then a soft reset must restore a changed field
    task automatic t_reset;
        logic [7:0] img [8] = '{8'h00, 8'ha0, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++)
            rd(7'h20 + 7'(i), img[i]);
        wr(7'h21, 8'h5a);
        chk(quanta_per_bit, 8'h5a);
        soft_reset <= 1'b1;
        @(posedge clk);
        soft_reset <= 1'b0;
        repeat (2) @(posedge clk);
        chk(quanta_per_bit, 8'ha0);
    endtask : t_reset

    // Every unlock code; only 11 unlocks trim and the option register
    task automatic t_ctrl;
        transmit_input_pin <= 1'b1;
        for (int u = 0; u < 4; u++)
        begin
            wr(7'h20, {1'b1, 2'(u), 5'h1e});
            rd(7'h20, {1'b1, 2'(u), 5'h10});
            chk1(trim_unlocked, u == 3);
            chk1(osc_trim_mode_enable, 1'b1);
            chk1(trim_sync_ref, u == 3);
            wr(7'h3e, 8'h01);
            chk1(low_power_rx_enable, u == 3);
        end
        wr(7'h20, 8'h40);
        wr(7'h3e, 8'h00);
        chk1(low_power_rx_enable, 1'b1);
        rd(7'h3e, 8'h01);
        chk1(osc_trim_mode_enable, 1'b0);
        chk1(trim_sync_ref, 1'b0);
        transmit_input_pin <= 1'b0;
    endtask : t_ctrl

    // Field widths and reserved bits read as zero
    task automatic t_fields;
        logic [23:0] tbl [4] = '{24'h215a5a, 24'h22ff3f, 24'h26ff7f, 24'h23c3c3};
        for (int i = 0; i < 4; i++)
        begin
            wr(tbl[i][22:16], tbl[i][15:8]);
            rd(tbl[i][22:16], tbl[i][7:0]);
        end
        chk(quanta_per_bit, 8'h5a);
        chk({2'h0, sample_point_fraction}, 8'h3f);
    endtask : t_fields

    // Valid bit set by the host, cleared by data change, wake-up and stop writes
    task automatic t_valid;
        wr(7'h20, 8'h01);
        chk1(wake_config_valid, 1'b1);
        wr(7'h21, 8'ha0);
        chk1(wake_config_valid, 1'b0);
        wr(7'h20, 8'h01);
        chk1(wake_config_valid, 1'b1);
        @(posedge clk) wake_event <= 1'b1;
        @(posedge clk) wake_event <= 1'b0;
        @(posedge clk);
        chk1(wake_config_valid, 1'b0);
        wr(7'h20, 8'h01);
        stop_mode <= 1'b1;
        wr(7'h20, 8'h01);
        chk1(wake_config_valid, 1'b0);
        stop_mode <= 1'b0;
    endtask : t_valid

    // One received frame; the pulse may land in any of three cycles
    task automatic frame(input logic arm, input logic [28:0] id, input logic ide,
                         input logic rtr, input logic [3:0] dlc, input logic exp);
        logic seen = 1'b0;
        if (arm)
            wr(7'h20, 8'h01);
        @(posedge clk);
        rx_frame_valid <= 1'b1;
        rx_frame       <= {id, ide, rtr, dlc};
        @(posedge clk);
        rx_frame_valid <= 1'b0;
        repeat (3)
        begin
            @(posedge clk);
            seen |= wake_up_frame;
        end
        chk1(seen, exp);
    endtask : frame

    task automatic t_match;
        wr(7'h23, WID[28:21]);
        wr(7'h24, WID[20:13]);
        wr(7'h25, WID[12:5]);
        wr(7'h26, {1'b0, WID[4:0], 2'b01});
        wr(7'h27, 8'hff);
        frame(1'b1, WID, 1'b1, 1'b0, 4'h3, 1'b1);
        frame(1'b0, WID, 1'b1, 1'b0, 4'h3, 1'b0);
        frame(1'b1, WID ^ 29'h1000, 1'b1, 1'b0, 4'h3, 1'b0);
        frame(1'b1, WID ^ 29'h1, 1'b1, 1'b0, 4'h3, 1'b1);
        frame(1'b1, WID, 1'b1, 1'b0, 4'h4, 1'b0);
        frame(1'b1, WID, 1'b1, 1'b1, 4'h3, 1'b0);
        frame(1'b1, WID, 1'b0, 1'b0, 4'h3, 1'b0);
        wr(7'h26, {1'b0, WID[4:0], 2'b00});
        frame(1'b1, WID ^ 29'h3ffff, 1'b0, 1'b0, 4'h3, 1'b1);
        frame(1'b1, WID ^ 29'h40000, 1'b0, 1'b0, 4'h3, 1'b0);
    endtask : t_match

    // Timeout event under a given control byte; stop mode is entered only after the write,
    // since a write in stop mode would drop the valid bit
    task automatic tmo(input logic [7:0] ctrl, input logic st, input logic ef, input logic ei);
        @(posedge clk) bus_timeout_clear <= 1'b1;
        @(posedge clk) bus_timeout_clear <= 1'b0;
        wr(7'h20, ctrl);
        stop_mode <= st;
        @(posedge clk) bus_timeout_event <= 1'b1;
        @(posedge clk) bus_timeout_event <= 1'b0;
        repeat (3) @(posedge clk);
        chk1(bus_timeout_flag, ef);
        chk1(bus_timeout_irq, ei);
    endtask : tmo

    task automatic test_done;
        $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done

    // Main sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_reset();
        t_ctrl();
        t_fields();
        t_valid();
        t_match();
        tmo(8'h11, 1'b0, 1'b1, 1'b1);
        tmo(8'h01, 1'b0, 1'b1, 1'b0);
        tmo(8'h10, 1'b0, 1'b0, 1'b0);
        normal_mode <= 1'b0;
        tmo(8'h11, 1'b0, 1'b1, 1'b0);
        tmo(8'h11, 1'b1, 1'b1, 1'b1);
        test_done();
    end

    // Watchdog: the run needs some 5000 cycles
    initial
    begin
        repeat (40000) @(posedge clk);
        miscompares++;
        test_done();
    end
endmodule : tb

bind cswk_config cswk_props u_props (
    .clk(clk),
    .rst_n(rst_n),
    .soft_reset(soft_reset),
    .normal_mode(normal_mode),
    .stop_mode(stop_mode),
    .wake_event(wake_event),
    .bus_timeout_event(bus_timeout_event),
    .transmit_input_pin(transmit_input_pin),
    .rx_frame_valid(rx_frame_valid),
    .spi_csn_n(spi_csn_n),
    .osc_trim_mode_enable(osc_trim_mode_enable),
    .trim_unlocked(trim_unlocked),
    .trim_sync_ref(trim_sync_ref),
    .wake_config_valid(wake_config_valid),
    .bus_timeout_flag(bus_timeout_flag),
    .bus_timeout_irq(bus_timeout_irq),
    .wake_up_frame(wake_up_frame)
);
`default_nettype wire
